/* common/dpdl_consts.svh */
`ifndef DPDL_CONSTS_SVH
`define DPDL_CONSTS_SVH

// ****************************************
// Register byte addresses
// ****************************************
`define DPDL_CTRL0_OFS   12'h000
`define DPDL_CTRL1_OFS   12'h004
`define DPDL_STAT_OFS    12'h008

// ****************************************
// Control byte field positions
// ****************************************
`define DPDL_POL_BIT     0
`define DPDL_DSEL_BIT    2
`define DPDL_CSLO_BIT    4
`define DPDL_CSHI_BIT    5
`define DPDL_STBY_BIT    6

// ****************************************
// Reset value and writable bits
// ****************************************
`define DPDL_CTRL_RST    8'h30
`define DPDL_CTRL_MASK   8'h75

// ****************************************
// Current fraction of full scale, percent
// ****************************************
`define DPDL_PCT_CODE0   7'h05
`define DPDL_PCT_CODE1   7'h32
`define DPDL_PCT_CODE2   7'h50
`define DPDL_PCT_CODE3   7'h64

`endif

/* common/dpdl_pkg.sv */
package dpdl_pkg;

    // Comparator arming sequence around standby
    typedef enum logic [1:0] {
        DPDL_STBY,
        DPDL_WAIT_REF,
        DPDL_RUN
    } dpdl_arm_e;

    typedef logic [6:0] dpdl_pct_t;
    typedef logic [7:0] dpdl_ctrl_t;

endpackage

/* common/dpdl_edge_if.sv */
`timescale 1ns/100ps

interface dpdl_edge_if #(
    parameter int N = 4
);
    logic [N-1:0] rawIn;
    logic [N-1:0] rise;

    modport sync (
        input  rawIn,
        output rise
    );
    modport user (
        output rawIn,
        input  rise
    );
endinterface

/* design/dpdl_sync.sv */
`timescale 1ns/100ps

module dpdl_sync #(
    parameter int N = 4
) (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic reset,
    // Pulse trains in, rising-edge strobes out
    dpdl_edge_if.sync bus
);

    logic [N-1:0] meta_ff;
    logic [N-1:0] sync_ff;
    logic [N-1:0] last_ff;
    logic [N-1:0] rise_ff;

    // ****************************************
    // Two-stage synchroniser
    // ****************************************
    // First stage feeds only the second stage
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= bus.rawIn;
            sync_ff <= meta_ff;
        end
    end

    // ****************************************
    // Rising edge strobes
    // ****************************************
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            last_ff <= '0;
            rise_ff <= '0;
        end else begin
            last_ff <= sync_ff;
            rise_ff <= sync_ff & ~last_ff;
        end
    end

    assign bus.rise = rise_ff;

endmodule // dpdl_sync

/* design/dpdl_top.sv */
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`include "dpdl_consts.svh"

module dpdl_top (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        reset,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Divided pulse trains, one bit per loop
    input  wire logic [1:0]  ref_divided_pulse,
    input  wire logic [1:0]  osc_divided_pulse,
    // Detector output pin, one per loop
    output logic      [1:0]  charge_pump_out_o,
    output logic      [1:0]  charge_pump_out_oe,
    // Companion pin: resistor pin or oscillator-phase output
    output logic      [1:0]  companion_out_o,
    output logic      [1:0]  companion_out_oe,
    // Lock indicator, open drain
    output logic      [1:0]  lock_indicator_out_o,
    output logic      [1:0]  lock_indicator_out_oe,
    // Current pump view for the analog stage
    output logic      [1:0]  pumpSource,
    output logic      [1:0]  pumpSink,
    output logic      [13:0] pumpLevel
);

    localparam int LOOPS = 2;

    // ****************************************
    // Pulse train synchronisers
    // ****************************************
    dpdl_edge_if #(.N(2 * LOOPS)) edgeBus ();

    assign edgeBus.rawIn = {osc_divided_pulse, ref_divided_pulse};

    dpdl_sync #(
        .N       (2 * LOOPS)
    ) u_sync (
        .ref_clk (ref_clk),
        .reset   (reset),
        .bus     (edgeBus.sync)
    );

    // ****************************************
    // APB decode
    // ****************************************
    logic                   accessPhase;
    logic                   setupPhase;
    logic [LOOPS-1:0]       hitCtrl;
    logic                   hitStat;
    logic                   addrHit;
    logic [31:0]            readMux;
    logic [31:0]            prdata_ff;
    dpdl_pkg::dpdl_ctrl_t   ctrlView [LOOPS];
    logic [3:0]             statView [LOOPS];

    assign setupPhase  = psel & ~penable;
    assign accessPhase = psel & penable;
    assign hitCtrl[0]  = (paddr == `DPDL_CTRL0_OFS);
    assign hitCtrl[1]  = (paddr == `DPDL_CTRL1_OFS);
    assign hitStat     = (paddr == `DPDL_STAT_OFS);
    assign addrHit     = (|hitCtrl) | hitStat;

    // Zero wait states: every access completes in its first access cycle
    assign pready  = 1'b1;
    assign pslverr = accessPhase & ~addrHit;

    always_comb begin
        readMux = 32'h0000_0000;
        if (hitCtrl[0]) begin
            readMux = {24'h00_0000, ctrlView[0]};
        end else if (hitCtrl[1]) begin
            readMux = {24'h00_0000, ctrlView[1]};
        end else if (hitStat) begin
            readMux = {24'h00_0000, statView[1], statView[0]};
        end
    end

    // Read data is caught in the setup cycle and held through the access
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            prdata_ff <= 32'h0000_0000;
        end else if (setupPhase & ~pwrite) begin
            prdata_ff <= readMux;
        end
    end

    assign prdata = prdata_ff;

    // ****************************************
    // Per-loop detector
    // ****************************************
    for (genvar g = 0; g < LOOPS; g++) begin : gLoop

        dpdl_pkg::dpdl_ctrl_t ctrl_ff;
        dpdl_pkg::dpdl_arm_e  arm_ff;
        dpdl_pkg::dpdl_arm_e  nxt_arm;
        dpdl_pkg::dpdl_pct_t  level_ff;
        dpdl_pkg::dpdl_pct_t  nxt_level;
        logic                 refRise;
        logic                 oscRise;
        logic                 polarity;
        logic                 detSel;
        logic                 standby;
        logic [1:0]           curSel;
        logic                 running;
        logic                 refFlag_ff;
        logic                 oscFlag_ff;
        logic                 bothSet;
        logic                 srcOn;
        logic                 sinkOn;
        logic                 refPhaseLow;
        logic                 oscPhaseLow;
        logic                 nxt_pinO;
        logic                 nxt_pinOe;
        logic                 nxt_compO;
        logic                 nxt_compOe;
        logic                 nxt_lockOe;
        logic                 pinO_ff;
        logic                 pinOe_ff;
        logic                 compO_ff;
        logic                 compOe_ff;
        logic                 lockOe_ff;
        logic                 src_ff;
        logic                 sink_ff;

        assign refRise  = edgeBus.rise[g];
        assign oscRise  = edgeBus.rise[LOOPS + g];
        assign polarity = ctrl_ff[`DPDL_POL_BIT];
        assign detSel   = ctrl_ff[`DPDL_DSEL_BIT];
        assign standby  = ctrl_ff[`DPDL_STBY_BIT];
        assign curSel   = {ctrl_ff[`DPDL_CSHI_BIT], ctrl_ff[`DPDL_CSLO_BIT]};

        // Control byte
        always_ff @(posedge ref_clk) begin
            if (reset) begin
                ctrl_ff <= `DPDL_CTRL_RST;
            end else if (accessPhase & pwrite & hitCtrl[g]) begin
                ctrl_ff <= pwdata[7:0] & `DPDL_CTRL_MASK;
            end
        end

        // Arming sequence
        // wait for reference
        always_comb begin
            nxt_arm = arm_ff;
            case (arm_ff)
                dpdl_pkg::DPDL_STBY: begin
                    if (!standby) begin
                        nxt_arm = dpdl_pkg::DPDL_WAIT_REF;
                    end
                end
                dpdl_pkg::DPDL_WAIT_REF: begin
                    if (standby) begin
                        nxt_arm = dpdl_pkg::DPDL_STBY;
                    end else if (refRise) begin
                        nxt_arm = dpdl_pkg::DPDL_RUN;
                    end
                end
                dpdl_pkg::DPDL_RUN: begin
                    if (standby) begin
                        nxt_arm = dpdl_pkg::DPDL_STBY;
                    end
                end
                default: begin
                    nxt_arm = dpdl_pkg::DPDL_STBY;
                end
            endcase
        end

        // Power-up behaves like leaving standby
        always_ff @(posedge ref_clk) begin
            if (reset) begin
                arm_ff <= dpdl_pkg::DPDL_WAIT_REF;
            end else begin
                arm_ff <= nxt_arm;
            end
        end

        assign running = (arm_ff == dpdl_pkg::DPDL_RUN);
        assign bothSet = refFlag_ff & oscFlag_ff;

        // Edge flags; a new edge in the clearing cycle wins
        always_ff @(posedge ref_clk) begin
            if (reset || !running) begin
                refFlag_ff <= 1'b0;
                oscFlag_ff <= 1'b0;
            end else begin
                refFlag_ff <= (refFlag_ff & ~bothSet) | refRise;
                oscFlag_ff <= (oscFlag_ff & ~bothSet) | oscRise;
            end
        end

        // Output selection
        always_comb begin
            sinkOn      = polarity ? refFlag_ff : oscFlag_ff;
            srcOn       = polarity ? oscFlag_ff : refFlag_ff;
            refPhaseLow = polarity ? oscFlag_ff : refFlag_ff;
            oscPhaseLow = polarity ? refFlag_ff : oscFlag_ff;
            if (standby) begin
                sinkOn      = 1'b0;
                srcOn       = 1'b0;
                refPhaseLow = 1'b0;
                oscPhaseLow = 1'b0;
            end
            if (detSel) begin
                nxt_pinO   = ~refPhaseLow;
                nxt_pinOe  = 1'b1;
                nxt_compO  = ~oscPhaseLow;
                nxt_compOe = 1'b1;
            end else begin
                // three-state pump, resistor pin released
                // Joint pulse shows on pumpSource/pumpSink; the pin floats then
                nxt_pinO   = srcOn;
                nxt_pinOe  = srcOn ^ sinkOn;
                nxt_compO  = 1'b0;
                nxt_compOe = 1'b0;
            end
            nxt_lockOe = standby | refPhaseLow | oscPhaseLow;
        end

        // Current level, off while the current is shut down in standby
        always_comb begin
            case (curSel)
                2'h0:    nxt_level = `DPDL_PCT_CODE0;
                2'h1:    nxt_level = `DPDL_PCT_CODE1;
                2'h2:    nxt_level = `DPDL_PCT_CODE2;
                2'h3:    nxt_level = `DPDL_PCT_CODE3;
                default: nxt_level = `DPDL_PCT_CODE3;
            endcase
            if (standby) begin
                nxt_level = 7'h00;
            end
        end

        // Pin registers
        always_ff @(posedge ref_clk) begin
            if (reset) begin
                pinO_ff   <= 1'b0;
                pinOe_ff  <= 1'b0;
                compO_ff  <= 1'b0;
                compOe_ff <= 1'b0;
                src_ff    <= 1'b0;
                sink_ff   <= 1'b0;
            end else begin
                pinO_ff   <= nxt_pinO;
                pinOe_ff  <= nxt_pinOe;
                compO_ff  <= nxt_compO;
                compOe_ff <= nxt_compOe;
                src_ff    <= srcOn;
                sink_ff   <= sinkOn;
            end
        end

        // Lock driver
        always_ff @(posedge ref_clk) begin
            if (reset) begin
                lockOe_ff <= 1'b0;
            end else begin
                lockOe_ff <= nxt_lockOe;
            end
        end

        always_ff @(posedge ref_clk) begin
            if (reset) begin
                level_ff <= `DPDL_PCT_CODE3;
            end else begin
                level_ff <= nxt_level;
            end
        end

        assign charge_pump_out_o[g]     = pinO_ff;
        assign charge_pump_out_oe[g]    = pinOe_ff;
        assign companion_out_o[g]       = compO_ff;
        assign companion_out_oe[g]      = compOe_ff;
        assign lock_indicator_out_o[g]  = 1'b0;
        assign lock_indicator_out_oe[g] = lockOe_ff;
        assign pumpSource[g]            = src_ff;
        assign pumpSink[g]              = sink_ff;
        assign pumpLevel[g*7 +: 7]      = level_ff;
        assign ctrlView[g]              = ctrl_ff;
        assign statView[g]              = {lockOe_ff, running, oscFlag_ff, refFlag_ff};
    end

endmodule // dpdl_top

/* tb/dpdl_top_assertions.sv */
`timescale 1ns/100ps

module dpdl_chk (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        reset,
    // Register bus
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    // Loop outputs
    input wire logic [1:0]  charge_pump_out_o,
    input wire logic [1:0]  charge_pump_out_oe,
    input wire logic [1:0]  companion_out_o,
    input wire logic [1:0]  companion_out_oe,
    input wire logic [1:0]  lock_indicator_out_o,
    input wire logic [1:0]  lock_indicator_out_oe,
    input wire logic [1:0]  pumpSource,
    input wire logic [1:0]  pumpSink,
    input wire logic [13:0] pumpLevel
);
    // ********
    // Checks
    // ********
    localparam logic [6:0] PCT [4] = '{7'h05, 7'h32, 7'h50, 7'h64};

    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);

    a_reset_state: assert property (
        $fell(reset) |-> lock_indicator_out_oe == 2'h0 && companion_out_oe == 2'h0
            && pumpLevel == {7'h64, 7'h64})
        else $error("lock, mode or level wrong after reset");
    a_drain_only: assert property (
        lock_indicator_out_oe != 2'h0 |-> lock_indicator_out_o == 2'h0)
        else $error("lock pin driven high");

    for (genvar g = 0; g < 2; g++) begin : gLoop
        logic stby;
        // Level zero marks standby, the current being shut off
        assign stby = pumpLevel[g*7 +: 7] == 7'h00;
        sequence ctrlWrite;
            psel && penable && pwrite && paddr == 12'(4 * g);
        endsequence
        a_level_code: assert property (
            ctrlWrite ##0 !pwdata[6] |-> ##2 pumpLevel[g*7 +: 7] == PCT[$past(pwdata[5:4], 2)])
            else $error("current level does not follow write");
        a_mode_pins: assert property (
            ctrlWrite |-> ##2 companion_out_oe[g] == $past(pwdata[2], 2))
            else $error("companion pin mode wrong");
        a_joint_once: assert property (
            pumpSource[g] && pumpSink[g] |=> !(pumpSource[g] && pumpSink[g]))
            else $error("joint state longer than one cycle");
        a_stby_quiet: assert property (
            stby |-> lock_indicator_out_oe[g] && !pumpSource[g] && !pumpSink[g]
                && (companion_out_oe[g] ? charge_pump_out_o[g] && companion_out_o[g]
                    : !charge_pump_out_oe[g]))
            else $error("standby outputs wrong");
        a_se_direction: assert property (
            !companion_out_oe[g] && charge_pump_out_oe[g] |->
                charge_pump_out_o[g] == pumpSource[g] && pumpSource[g] != pumpSink[g])
            else $error("single-ended pin disagrees with pump");
        a_lock_pumps: assert property (
            !stby && !$past(stby) |-> lock_indicator_out_oe[g] == (pumpSource[g] || pumpSink[g]))
            else $error("lock does not track phase error");
        a_lock_and: assert property (
            companion_out_oe[g] && !stby |->
                lock_indicator_out_oe[g] == !(charge_pump_out_o[g] && companion_out_o[g]))
            else $error("lock is not the AND of phase outputs");
    end
endmodule // dpdl_chk

bind dpdl_top dpdl_chk u_chk (.*);

/* tb/dpdl_vco_model.sv */
`timescale 1ns/100ps

module dpdl_vco_model (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       reset,
    // Lock pin from the device
    input  wire logic [1:0] lockO,
    input  wire logic [1:0] lockOe,
    // Bench strobe: one oscillator pulse each
    input  wire logic [1:0] fire,
    // Divided oscillator train, pulled-up lock line
    output logic      [1:0] oscPulse,
    output logic      [1:0] lockWire
);
    // ********
    // Oscillator
    // ********
    logic [1:0] widthCnt_ff [2];

    // Pulse held 3 cycles, above the synchronizer minimum
    always_ff @(posedge ref_clk) begin
        for (int g = 0; g < 2; g++) begin
            if (reset || fire[g]) begin
                widthCnt_ff[g] <= reset ? 2'h0 : 2'h3;
            end else if (widthCnt_ff[g] != 2'h0) begin
                widthCnt_ff[g] <= widthCnt_ff[g] - 2'h1;
            end
        end
    end

    always_comb begin
        for (int g = 0; g < 2; g++) begin
            oscPulse[g] = widthCnt_ff[g] != 2'h0;
        end
    end

    assign lockWire = ~lockOe | lockO;
endmodule // dpdl_vco_model

/* tb/tb_dual_phase_detector_lock.sv */
`timescale 1ns/100ps

module tb_dual_phase_detector_lock;
    // ********
    // Bench
    // ********
    logic        ref_clk = 1'b0;
    logic        reset = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [1:0]  ref_divided_pulse = 2'h0;
    logic [1:0]  osc_divided_pulse;
    logic [1:0]  charge_pump_out_o;
    logic [1:0]  charge_pump_out_oe;
    logic [1:0]  companion_out_o;
    logic [1:0]  companion_out_oe;
    logic [1:0]  lock_indicator_out_o;
    logic [1:0]  lock_indicator_out_oe;
    logic [1:0]  pumpSource;
    logic [1:0]  pumpSink;
    logic [13:0] pumpLevel;
    logic [1:0]  lockWire;
    logic [1:0]  fire = 2'h0;
    logic [31:0] q;
    logic        e;
    logic [4:0]  s;
    logic [4:0]  f;
    int          j;
    int          jointCnt [2] = '{0, 0};
    int          errTotal = 0;
    int          testsRun = 0;
    logic [6:0]  pct [4] = '{7'h05, 7'h32, 7'h50, 7'h64};

    always #5 ref_clk = ~ref_clk;

    dpdl_top uut (.*);

    dpdl_vco_model farSide (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .lockO    (lock_indicator_out_o),
        .lockOe   (lock_indicator_out_oe),
        .fire     (fire),
        .oscPulse (osc_divided_pulse),
        .lockWire (lockWire)
    );

    always @(posedge ref_clk) begin
        for (int g = 0; g < 2; g++) begin
            if (pumpSource[g] === 1'b1 && pumpSink[g] === 1'b1) begin
                jointCnt[g] <= jointCnt[g] + 1;
            end
        end
    end

    // Pin view; an undriven detector or companion pin level is masked to zero, the lock line reads its pull-up
    function automatic logic [4:0] snapOf(input int g);
        snapOf = {charge_pump_out_oe[g], charge_pump_out_oe[g] & charge_pump_out_o[g],
                  companion_out_oe[g], companion_out_oe[g] & companion_out_o[g], lockWire[g]};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        testsRun++;
        if (seen !== exp) begin
            errTotal++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic closeOut();
        if (errTotal == 0 && testsRun > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        // Waits as long as the slave stretches; only the watchdog ends a hang
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Mid snapshot lands between the two edges, final one after release
    task automatic pair(input int g, input int oscAt, input int refAt);
        for (int i = 0; i < 25; i++) begin
            @(posedge ref_clk);
            fire[g] <= (i == oscAt);
            ref_divided_pulse[g] <= (i > refAt && i < refAt + 4);
            #1;
            if (i == 9) s = snapOf(g);
        end
        f = snapOf(g);
    endtask

    initial begin
        repeat (5000) @(posedge ref_clk);
        errTotal++;
        closeOut();
    end

    initial begin
        repeat (5) @(posedge ref_clk);
        reset <= 1'b0;
        apb(1'b0, 12'h000, 32'h0);
        check(q, 32'h30);
        check(pumpLevel, 14'h3264);
        apb(1'b1, 12'h004, 32'hff);
        apb(1'b0, 12'h004, 32'h0);
        check(q, 32'h75);
        apb(1'b0, 12'h000, 32'h0);
        check(q, 32'h30);
        apb(1'b0, 12'h00c, 32'h0);
        check(e, 1'b1);
        for (int g = 0; g < 2; g++) begin
            for (int k = 0; k < 4; k++) begin
                apb(1'b1, 12'(4 * g), 32'(k << 4));
                repeat (2) @(posedge ref_clk);
                check(pumpLevel[g*7 +: 7], pct[k]);
            end
            pair(g, 7, 0);
            check(f, 5'h10);
            // Status: this loop armed with a lone oscillator flag, the other idle
            apb(1'b0, 12'h008, 32'h0);
            check(q, (g == 0) ? 32'h8e : 32'he4);
            pair(g, 0, 6);
            check(s, 5'h10);
            check(f, 5'h01);
            pair(g, 7, 0);
            check(s, 5'h18);
            j = jointCnt[g];
            pair(g, 0, 0);
            check(jointCnt[g] - j, 32'h1);
            check(f, 5'h01);
            apb(1'b1, 12'(4 * g), 32'h31);
            pair(g, 0, 6);
            check(s, 5'h18);
            apb(1'b1, 12'(4 * g), 32'h34);
            pair(g, 0, 6);
            check(s, 5'h1c);
            check(f, 5'h1f);
            pair(g, 7, 0);
            check(s, 5'h16);
            apb(1'b1, 12'(4 * g), 32'h35);
            pair(g, 0, 6);
            check(s, 5'h16);
            apb(1'b1, 12'(4 * g), 32'h74);
            pair(g, 0, 6);
            check(s, 5'h1e);
            apb(1'b1, 12'(4 * g), 32'h70);
            pair(g, 0, 6);
            check(s, 5'h00);
            apb(1'b1, 12'(4 * g), 32'h30);
            pair(g, 7, 0);
            check(f, 5'h10);
            pair(g, 0, 6);
            check(f, 5'h01);
        end
        closeOut();
    end
endmodule // tb_dual_phase_detector_lock
